/* logic/odr_pkg.sv */
// Package for the output divider and lock-loss mask register bank.
// Assumes a byte-wide register port fed by the serial control port engine.
package odr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ODR_LOCK_LOSS_IRQ_MASK_OFS    = 8'h18;
    localparam logic [7:0] ODR_SHARED_HS_OUT_DIVIDER_OFS = 8'h19;
    localparam logic [7:0] ODR_OUT1_DIVIDER_TOP_OFS      = 8'h1F;
    localparam logic [7:0] ODR_OUT1_DIVIDER_MID_OFS      = 8'h20;
    localparam logic [7:0] ODR_OUT1_DIVIDER_LOW_OFS      = 8'h21;
    localparam logic [7:0] ODR_OUT2_DIVIDER_TOP_OFS      = 8'h22;
    localparam logic [7:0] ODR_OUT2_DIVIDER_MID_OFS      = 8'h23;
    localparam logic [7:0] ODR_OUT2_DIVIDER_LOW_OFS      = 8'h24;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ODR_LOCK_LOSS_IRQ_MASK_RST    = 8'h3F;
    localparam logic [7:0] ODR_SHARED_HS_OUT_DIVIDER_RST = 8'h20;
    localparam logic [7:0] ODR_OUT1_DIVIDER_TOP_RST      = 8'h00;
    localparam logic [7:0] ODR_OUT1_DIVIDER_MID_RST      = 8'h00;
    localparam logic [7:0] ODR_OUT1_DIVIDER_LOW_RST      = 8'h31;
    localparam logic [7:0] ODR_OUT2_DIVIDER_TOP_RST      = 8'h00;
    localparam logic [7:0] ODR_OUT2_DIVIDER_MID_RST      = 8'h00;
    localparam logic [7:0] ODR_OUT2_DIVIDER_LOW_RST      = 8'h31;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int         ODR_MASK_BIT        = 0;
    localparam int         ODR_HS_CODE_LSB     = 5;
    localparam int         ODR_HS_CODE_W       = 3;
    localparam int         ODR_LS_W            = 20;
    localparam int         ODR_TOP_NIBBLE_W    = 4;
    localparam logic [3:0] ODR_HS_RATIO_OFFSET = 4'h4;
    localparam logic [7:0] ODR_UNMAPPED_RDATA  = 8'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } odr_reg_req_t;

    typedef struct packed {
        logic                     irq_mask;
        logic [ODR_HS_CODE_W-1:0] hs_code;
        logic [ODR_LS_W-1:0]      out1_ls;
        logic [ODR_LS_W-1:0]      out2_ls;
        logic [7:0]               rdata;
    } odr_state_t;

endpackage

/* logic/odr_tick_div.sv */
// Tick divider: emits one tick for every (max_count + 1) input ticks.
// Assumes in_tick is a single-cycle strobe on core_clk.
`timescale 1ns/100ps
module odr_tick_div #(
    parameter int WIDTH = 20
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // Division control
    input  wire logic [WIDTH-1:0] max_count,
    input  wire logic             in_tick,
    // Divided strobe
    output logic                  out_tick
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             tick;
    } odr_div_state_t;

    odr_div_state_t state_reg;
    odr_div_state_t state_next;

    // Elaboration check: a one-bit counter cannot hold a useful ratio
    if (WIDTH < 2) begin : g_bad_width
        $error("odr_tick_div WIDTH must be at least 2");
    end

    // Count input ticks; a shrinking ratio wraps at once rather than running out
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (in_tick) begin
            if (state_reg.cnt >= max_count) begin
                state_next.cnt  = '0;
                state_next.tick = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt + WIDTH'(1);
            end
        end
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign out_tick = state_reg.tick;

endmodule

/* logic/odr_regs.sv */
// Output divider and lock-loss interrupt mask register bank.
// Assumes a serial control port engine presenting byte register accesses,
// and lock_loss_flag / other interrupt sources from logic on core_clk.
`timescale 1ns/100ps
module odr_regs (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // Register port
    input  wire odr_pkg::odr_reg_req_t reg_req,
    output logic [7:0]                reg_rdata,
    // Alarm sources
    input  wire logic                 lock_loss_flag,
    input  wire logic                 other_irq_status,
    input  wire logic                 irq_route_enable,
    // Shared interrupt pin
    output logic                      shared_irq_los_pin_out,
    output logic                      shared_irq_los_pin_oe,
    // Clock generation
    input  wire logic                 src_tick,
    output logic                      hs_tick,
    output logic                      clock_output_first,
    output logic                      clock_output_second,
    // Decoded divider settings
    output logic [3:0]                hs_ratio,
    output logic [19:0]               out1_ls_divider,
    output logic [19:0]               out2_ls_divider
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    odr_pkg::odr_state_t state_reg;
    odr_pkg::odr_state_t state_next;

    localparam int LSW = odr_pkg::ODR_LS_W;
    localparam int HSL = odr_pkg::ODR_HS_CODE_LSB;
    localparam int TNW = odr_pkg::ODR_TOP_NIBBLE_W;

    logic             irq_status;
    logic [LSW-1:0]   ls_max [2];
    logic [1:0]       ls_tick;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The ports are fixed at the documented widths, so the package must agree
    if (LSW != 20 || TNW + 16 != LSW) begin : g_bad_ls_width
        $error("odr_regs low-speed divider fields must total twenty bits");
    end
    // Read-back packs the code above the reserved bits, filling one byte
    if (HSL + odr_pkg::ODR_HS_CODE_W != 8) begin : g_bad_hs_pos
        $error("odr_regs high-speed code must end at the top bit of its byte");
    end
    // Top code plus four must fit hs_ratio and the four-bit stage counter
    if ((1 << odr_pkg::ODR_HS_CODE_W) + int'(odr_pkg::ODR_HS_RATIO_OFFSET) > 16) begin : g_bad_hs_ratio
        $error("odr_regs high-speed ratio does not fit four bits");
    end
    // Read-back places the mask in bit zero next to the reserved pattern
    if (odr_pkg::ODR_MASK_BIT != 0) begin : g_bad_mask_pos
        $error("odr_regs mask bit must be bit zero");
    end

    // Register writes and registered read data
    always_comb begin
        state_next = state_reg;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                odr_pkg::ODR_LOCK_LOSS_IRQ_MASK_OFS: begin
                    // Only the mask moves; the flag is an input and is never stored here
                    state_next.irq_mask = reg_req.wdata[odr_pkg::ODR_MASK_BIT];
                end
                odr_pkg::ODR_SHARED_HS_OUT_DIVIDER_OFS: begin
                    state_next.hs_code = reg_req.wdata[HSL +: odr_pkg::ODR_HS_CODE_W];
                end
                odr_pkg::ODR_OUT1_DIVIDER_TOP_OFS: begin
                    state_next.out1_ls[19:16] = reg_req.wdata[TNW-1:0];
                end
                odr_pkg::ODR_OUT1_DIVIDER_MID_OFS: begin
                    state_next.out1_ls[15:8] = reg_req.wdata;
                end
                odr_pkg::ODR_OUT1_DIVIDER_LOW_OFS: begin
                    state_next.out1_ls[7:0] = reg_req.wdata;
                end
                odr_pkg::ODR_OUT2_DIVIDER_TOP_OFS: begin
                    state_next.out2_ls[19:16] = reg_req.wdata[TNW-1:0];
                end
                odr_pkg::ODR_OUT2_DIVIDER_MID_OFS: begin
                    state_next.out2_ls[15:8] = reg_req.wdata;
                end
                odr_pkg::ODR_OUT2_DIVIDER_LOW_OFS: begin
                    state_next.out2_ls[7:0] = reg_req.wdata;
                end
                default: begin
                    state_next.out2_ls = state_reg.out2_ls;
                end
            endcase
        end
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                // Reserved bits read back their reset pattern
                odr_pkg::ODR_LOCK_LOSS_IRQ_MASK_OFS: begin
                    state_next.rdata = {odr_pkg::ODR_LOCK_LOSS_IRQ_MASK_RST[7:1], state_reg.irq_mask};
                end
                odr_pkg::ODR_SHARED_HS_OUT_DIVIDER_OFS: begin
                    state_next.rdata = {state_reg.hs_code,
                                        odr_pkg::ODR_SHARED_HS_OUT_DIVIDER_RST[HSL-1:0]};
                end
                odr_pkg::ODR_OUT1_DIVIDER_TOP_OFS: begin
                    state_next.rdata = {odr_pkg::ODR_OUT1_DIVIDER_TOP_RST[7:4], state_reg.out1_ls[19:16]};
                end
                odr_pkg::ODR_OUT1_DIVIDER_MID_OFS: begin
                    state_next.rdata = state_reg.out1_ls[15:8];
                end
                odr_pkg::ODR_OUT1_DIVIDER_LOW_OFS: begin
                    state_next.rdata = state_reg.out1_ls[7:0];
                end
                odr_pkg::ODR_OUT2_DIVIDER_TOP_OFS: begin
                    state_next.rdata = {odr_pkg::ODR_OUT2_DIVIDER_TOP_RST[7:4], state_reg.out2_ls[19:16]};
                end
                odr_pkg::ODR_OUT2_DIVIDER_MID_OFS: begin
                    state_next.rdata = state_reg.out2_ls[15:8];
                end
                odr_pkg::ODR_OUT2_DIVIDER_LOW_OFS: begin
                    state_next.rdata = state_reg.out2_ls[7:0];
                end
                default: begin
                    state_next.rdata = odr_pkg::ODR_UNMAPPED_RDATA;
                end
            endcase
        end
    end

    // Register the state; reset loads the power-up defaults
    // Reserved bits have no storage, so reset touches only the fields
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg.irq_mask <= odr_pkg::ODR_LOCK_LOSS_IRQ_MASK_RST[odr_pkg::ODR_MASK_BIT];
            state_reg.hs_code  <= odr_pkg::ODR_SHARED_HS_OUT_DIVIDER_RST[HSL +: odr_pkg::ODR_HS_CODE_W];
            state_reg.out1_ls  <= {odr_pkg::ODR_OUT1_DIVIDER_TOP_RST[TNW-1:0],
                                   odr_pkg::ODR_OUT1_DIVIDER_MID_RST,
                                   odr_pkg::ODR_OUT1_DIVIDER_LOW_RST};
            state_reg.out2_ls  <= {odr_pkg::ODR_OUT2_DIVIDER_TOP_RST[TNW-1:0],
                                   odr_pkg::ODR_OUT2_DIVIDER_MID_RST,
                                   odr_pkg::ODR_OUT2_DIVIDER_LOW_RST};
            state_reg.rdata    <= odr_pkg::ODR_UNMAPPED_RDATA;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt combine and shared pin
    // ------------------------------------------------------------------
    // Mask only gates the flag's contribution; other sources pass untouched
    assign irq_status = (lock_loss_flag & ~state_reg.irq_mask)
                      | other_irq_status;
    // Pin released (not driven) while routing is off
    assign shared_irq_los_pin_out = irq_status & irq_route_enable;
    assign shared_irq_los_pin_oe  = irq_route_enable;

    // Read data holds until the next read strobe replaces it
    assign reg_rdata = state_reg.rdata;

    // ------------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------------
    assign hs_ratio        = {1'b0, state_reg.hs_code} + odr_pkg::ODR_HS_RATIO_OFFSET;
    assign out1_ls_divider = state_reg.out1_ls;
    assign out2_ls_divider = state_reg.out2_ls;

    // Common high-speed stage; width 4 holds max count of 10
    odr_tick_div #(
        .WIDTH (4)
    ) u_hs_div (
        .core_clk  (core_clk),
        .srst      (srst),
        .max_count (hs_ratio - 4'h1),
        .in_tick   (src_tick),
        .out_tick  (hs_tick)
    );

    // Per-output low-speed stages share the high-speed tick
    generate
        for (genvar i = 0; i < 2; i++) begin : g_ls
            logic [LSW-1:0] ls_val;
            assign ls_val = (i == 0) ? state_reg.out1_ls : state_reg.out2_ls;
            // Zero means divide by one; even values are software's fault and divide as written
            assign ls_max[i] = (ls_val == '0) ? '0 : ls_val - LSW'(1);
            odr_tick_div #(
                .WIDTH (LSW)
            ) u_ls_div (
                .core_clk  (core_clk),
                .srst      (srst),
                .max_count (ls_max[i]),
                .in_tick   (hs_tick),
                .out_tick  (ls_tick[i])
            );
        end
    endgenerate

    assign clock_output_first  = ls_tick[0];
    assign clock_output_second = ls_tick[1];

endmodule

/* sim/odr_regs_checker.sv */
// Assertions on the ports of the output divider and lock-loss mask register bank.
// Assumes one core_clk domain with synchronous active-high srst; bound at the foot.
`timescale 1ns/100ps
module odr_regs_checker (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  srst,
    // Register port
    input wire odr_pkg::odr_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    // Alarm sources and shared pin
    input wire logic                  lock_loss_flag,
    input wire logic                  other_irq_status,
    input wire logic                  irq_route_enable,
    input wire logic                  shared_irq_los_pin_out,
    input wire logic                  shared_irq_los_pin_oe,
    // Divider chain
    input wire logic                  src_tick,
    input wire logic                  hs_tick,
    input wire logic                  clock_output_first,
    input wire logic                  clock_output_second,
    input wire logic [3:0]            hs_ratio,
    input wire logic [19:0]           out1_ls_divider,
    input wire logic [19:0]           out2_ls_divider
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------------
    // Write steps
    // ------------------------------------------------------------------
    // A taken write to one offset; later steps look one cycle on
    sequence s_wr(logic [7:0] a);
        reg_req.wr && reg_req.addr == a;
    endsequence

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    AST_MASK_CLEAR: assert property (s_wr(8'h18) ##0 !reg_req.wdata[0] ##1 (lock_loss_flag && irq_route_enable)
        |-> shared_irq_los_pin_out) else $error("unmasked lock loss not on pin");
    AST_MASK_SET: assert property (s_wr(8'h18) ##0 reg_req.wdata[0] ##1 !other_irq_status
        |-> !shared_irq_los_pin_out) else $error("masked lock loss reached pin");
    AST_ROUTE: assert property (shared_irq_los_pin_oe == irq_route_enable
        && (!(irq_route_enable && other_irq_status) || shared_irq_los_pin_out)
        && (irq_route_enable || !shared_irq_los_pin_out)) else $error("pin routing wrong");

    // ------------------------------------------------------------------
    // Divider fields
    // ------------------------------------------------------------------
    AST_HS_RATIO: assert property (s_wr(8'h19) |=> hs_ratio == {1'b0, $past(reg_req.wdata[7:5])} + 4'h4)
        else $error("high-speed ratio not code plus four");
    AST_OUT1_TOP: assert property (s_wr(8'h1f) |=> out1_ls_divider[19:16] == $past(reg_req.wdata[3:0]))
        else $error("output one top nibble misplaced");
    AST_OUT2_MID: assert property (s_wr(8'h23) |=> out2_ls_divider[15:8] == $past(reg_req.wdata))
        else $error("output two middle byte misplaced");
    AST_OUT2_LOW: assert property (s_wr(8'h24) |=> out2_ls_divider[7:0] == $past(reg_req.wdata))
        else $error("output two low byte misplaced");
    AST_HS_FEED: assert property (clock_output_first || clock_output_second |-> $past(hs_tick))
        else $error("output tick without shared divider tick");
    AST_HS_RSV: assert property (reg_req.rd && reg_req.addr == 8'h19 |=> reg_rdata[4:0] == 5'h00)
        else $error("reserved divider bits read non-zero");
    AST_RST_VAL: assert property ($fell(srst) |-> hs_ratio == 4'h5 && out1_ls_divider == 20'h0_0031
        && out2_ls_divider == 20'h0_0031) else $error("divider reset values wrong");
endmodule

bind odr_regs odr_regs_checker chk_u (.*);

/* sim/odr_regs_tb.sv */
// Self-checking bench for the output divider register bank.
// Assumes the checker file is compiled with it and binds itself to the design.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module odr_regs_tb;
    // ------------------------------------------------------------------
    // Design signals
    // ------------------------------------------------------------------
    logic                  core_clk = 1'b0;
    logic                  srst = 1'b1;
    odr_pkg::odr_reg_req_t reg_req = '0;
    logic [7:0]            reg_rdata;
    logic                  lock_loss_flag = 1'b0;
    logic                  other_irq_status = 1'b0;
    logic                  irq_route_enable = 1'b0;
    logic                  shared_irq_los_pin_out;
    logic                  shared_irq_los_pin_oe;
    logic                  src_tick = 1'b0;
    logic                  hs_tick;
    logic                  clock_output_first;
    logic                  clock_output_second;
    logic [3:0]            hs_ratio;
    logic [19:0]           out1_ls_divider;
    logic [19:0]           out2_ls_divider;
    int                    error_cnt = 0;
    int                    n_tests = 0;
    int                    cyc = 0;
    int                    hc, c1, c2;
    // Offsets, reset values and read-back after writing all ones
    logic [7:0] ad [8] = '{8'h18, 8'h19, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
    logic [7:0] rv [8] = '{8'h3f, 8'h20, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31};
    logic [7:0] fv [8] = '{8'h3f, 8'he0, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};

    odr_regs dut_u (.*);

    // 100 ns period clock; the watchdog stops a hung run
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    // One-cycle strobe, then wait to the falling edge so decoded outputs settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req <= '0;
        @(negedge core_clk);
    endtask
    // Read data is registered, so it is looked at one cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req <= '0;
        @(negedge core_clk);
        `CHK(reg_rdata, e)
    endtask
    task automatic setin(input logic f, input logic o, input logic r);
        @(posedge core_clk);
        lock_loss_flag <= f;
        other_irq_status <= o;
        irq_route_enable <= r;
        @(negedge core_clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) rchk(ad[i], rv[i]);
        `CHK(hs_ratio, 4'h5)
        rchk(8'h30, 8'h00);
        $display("test reset values done");
        // Reserved bits must not take the ones
        for (int i = 0; i < 8; i++) wr(ad[i], 8'hff);
        for (int i = 0; i < 8; i++) rchk(ad[i], fv[i]);
        `CHK(out1_ls_divider, 20'hf_ffff)
        `CHK(out2_ls_divider, 20'hf_ffff)
        for (int c = 0; c < 8; c++) begin
            wr(8'h19, 8'(c << 5));
            `CHK(hs_ratio, 4'(c + 4))
        end
        $display("test fields done");
        // Mask clear lets lock loss through, routing gates the pin
        wr(8'h18, 8'h00);
        rchk(8'h18, 8'h3e);
        setin(1'b1, 1'b0, 1'b1);
        `CHK({shared_irq_los_pin_out, shared_irq_los_pin_oe}, 2'b11)
        setin(1'b1, 1'b0, 1'b0);
        `CHK({shared_irq_los_pin_out, shared_irq_los_pin_oe}, 2'b00)
        setin(1'b1, 1'b0, 1'b1);
        wr(8'h18, 8'h01);
        `CHK(shared_irq_los_pin_out, 1'b0)
        setin(1'b1, 1'b1, 1'b1);
        `CHK(shared_irq_los_pin_out, 1'b1)
        // Clearing the mask with the flag standing puts it back on the pin
        setin(1'b1, 1'b0, 1'b1);
        wr(8'h18, 8'h00);
        `CHK(shared_irq_los_pin_out, 1'b1)
        setin(1'b0, 1'b0, 1'b0);
        $display("test interrupt done");
        // Byte assembly of both low-speed dividers
        wr(8'h1f, 8'h0a);
        wr(8'h20, 8'hbc);
        wr(8'h21, 8'hdf);
        `CHK(out1_ls_divider, 20'ha_bcdf)
        wr(8'h22, 8'h01);
        wr(8'h23, 8'h23);
        wr(8'h24, 8'h45);
        `CHK(out2_ls_divider, 20'h1_2345)
        // Ratio 4, output one zero means one, output two three
        wr(8'h19, 8'h00);
        wr(8'h1f, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h21, 8'h00);
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h00);
        wr(8'h24, 8'h03);
        @(posedge core_clk);
        src_tick <= 1'b1;
        repeat (40) @(posedge core_clk);
        hc = 0;
        c1 = 0;
        c2 = 0;
        // A 24-cycle window holds a whole number of every period
        repeat (24) begin
            @(negedge core_clk);
            hc += int'(hs_tick === 1'b1);
            c1 += int'(clock_output_first === 1'b1);
            c2 += int'(clock_output_second === 1'b1);
        end
        @(posedge core_clk);
        src_tick <= 1'b0;
        `CHK(hc, 6)
        `CHK(c1, 6)
        `CHK(c2, 2)
        $display("test dividers done");
        finish_test();
    end
endmodule
